// ### dv/serial_peer.sv
// Remote serial peer: decodes the transmit line, drives the receive pin
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic line,
  input wire logic inv,
  input wire logic nine,
  input var int bit_clks,
  output logic rxd
);
  logic [8:0] got[$];
  logic [9:0] sh;
  int nb;
  initial rxd = 1'b1;
  always begin
    @(negedge clk);
    nb = nine ? 9 : 8;
    if ((line ^ inv) === 1'b0) begin
      repeat (bit_clks / 2) @(negedge clk);
      // Polarity switch glitch is shorter than half a bit
      if ((line ^ inv) === 1'b0) begin
        for (int i = 0; i <= nb; i++) begin
          repeat (bit_clks) @(negedge clk);
          sh[i] = line ^ inv;
        end
        got.push_back(sh[nb] !== 1'b1 ? 9'bx : (nine ? sh[8:0] : {1'b0, sh[7:0]}));
      end
    end
  end
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    rxd = 1'b0;
    repeat (bit_clks) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rxd = d[i];
      repeat (bit_clks) @(negedge clk);
    end
    rxd = stop;
    repeat (bit_clks) @(negedge clk);
    rxd = 1'b1;
    repeat (bit_clks) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/serial_port_monitor.sv
// Concurrent checks on the serial port pins
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
module serial_port_monitor (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic TX_ENABLE_BIT,
  input wire logic SYNC_MODE,
  input wire logic SERIAL_PORT_ENABLE,
  input wire logic TX_POLARITY_BIT,
  input wire logic TX_INTERRUPT_ENABLE,
  input wire logic TX_HOLDING_BUFFER_WRITE,
  input wire logic TX_CLOCK_PIN_OUT,
  input wire logic TX_CLOCK_PIN_OE_N,
  input wire logic TX_BUFFER_EMPTY_FLAG,
  input wire logic TX_IRQ,
  input wire logic TX_BUSY,
  input wire logic RX_READY_FLAG,
  input wire logic FRAMING_ERROR_FLAG,
  input wire logic [`DATA_W_DEF-1:0] RX_DATA_BUFFER,
  input wire logic BREAK_DETECTED
);
  wire logic act = TX_ENABLE_BIT && !SYNC_MODE && SERIAL_PORT_ENABLE;
  wire logic brk = RX_READY_FLAG && FRAMING_ERROR_FLAG && RX_DATA_BUFFER[7:0] == `BREAK_BYTE;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  sequence tx_off;
    !act [*8];
  endsequence
  // Only a lone write into an idle shifter; later writes may queue
  sequence lone_write;
    TX_HOLDING_BUFFER_WRITE && !$past(TX_HOLDING_BUFFER_WRITE) && act && !TX_BUSY;
  endsequence
  chk_flag_off_idle: assert property (tx_off |-> !TX_BUFFER_EMPTY_FLAG)
    else $error("empty flag set while off");
  chk_idle_level: assert property (
    tx_off |-> SYNC_MODE || TX_CLOCK_PIN_OUT != TX_POLARITY_BIT)
    else $error("line not at idle level");
  chk_oe_on_port: assert property ($rose(SERIAL_PORT_ENABLE) |=> !TX_CLOCK_PIN_OE_N)
    else $error("pin not driven after port enable");
  chk_empty_on_enable: assert property ($rose(act) |-> ##[1:8] TX_BUFFER_EMPTY_FLAG)
    else $error("empty flag not set on enable");
  chk_first_keeps_flag: assert property (
    lone_write ##0 TX_BUFFER_EMPTY_FLAG |=> TX_BUFFER_EMPTY_FLAG [*4])
    else $error("flag dropped by direct load");
  chk_irq_needs_both: assert property (
    TX_IRQ |-> $past(TX_BUFFER_EMPTY_FLAG && TX_INTERRUPT_ENABLE))
    else $error("irq without flag and enable");
  chk_break_cause: assert property (BREAK_DETECTED |-> $past(brk))
    else $error("break without cause");
  chk_break_seen: assert property (brk |=> BREAK_DETECTED)
    else $error("break missed");
endmodule
bind serial_port serial_port_monitor i_mon (.*);
`default_nettype wire

// ### dv/serial_port_tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
  logic CLK_SYS = 0, SRST = 1, TX_ENABLE_BIT = 0, RX_ENABLE = 1, SYNC_MODE = 0;
  logic SERIAL_PORT_ENABLE = 0, TX_POLARITY_BIT = 0, NINE_BIT_MODE = 0, BRG_16BIT = 0;
  logic TX_INTERRUPT_ENABLE = 0, WAKE_ON_BREAK = 0, TX_HOLDING_BUFFER_WRITE = 0, RX_DATA_READ = 0;
  logic [15:0] BRG_DIVISOR = 16'h0107;
  logic [8:0] TX_HOLDING_BUFFER = 9'h000;
  logic RX_DATA_PIN, TX_CLOCK_PIN_OUT, TX_CLOCK_PIN_OE_N, TX_HOLDING_READY, TX_BUFFER_EMPTY_FLAG;
  logic TX_IRQ, TX_BUSY, RX_READY_FLAG, FRAMING_ERROR_FLAG, BREAK_DETECTED, WAKE_ACTIVE;
  logic [8:0] RX_DATA_BUFFER;
  logic [8:0] exp[$];
  logic lo, refd;
  int errors = 0, comparisons = 0, bit_clks = 8;
  always #2.5 CLK_SYS = ~CLK_SYS;
  serial_port i_dut (.*);
  // Released pin floats high through the pull-up
  serial_peer i_peer (.clk(CLK_SYS), .line(TX_CLOCK_PIN_OE_N ? 1'b1 : TX_CLOCK_PIN_OUT),
    .inv(TX_POLARITY_BIT), .nine(NINE_BIT_MODE), .bit_clks(bit_clks), .rxd(RX_DATA_PIN));
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string n, input logic [8:0] seen, input logic [8:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, want, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  task automatic put(input logic [8:0] d);
    TX_HOLDING_BUFFER = d;
    TX_HOLDING_BUFFER_WRITE = 1'b1;
    exp.push_back(d);
    step(1);
    TX_HOLDING_BUFFER_WRITE = 1'b0;
  endtask
  task automatic drain();
    for (int i = 0; i < 6000 && i_peer.got.size() < exp.size(); i++) step(1);
    check("frames", 9'(i_peer.got.size()), 9'(exp.size()));
    if (i_peer.got.size() < exp.size()) finish_test();
    foreach (exp[i]) check("tx_char", i_peer.got[i], exp[i]);
    exp.delete();
    i_peer.got.delete();
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 4000 && RX_READY_FLAG !== 1'b1; i++) step(1);
    check("rx_ready", RX_READY_FLAG, 1'b1);
    if (RX_READY_FLAG !== 1'b1) finish_test();
  endtask
  task automatic rd();
    RX_DATA_READ = 1'b1;
    step(1);
    RX_DATA_READ = 1'b0;
    step(1);
  endtask
  initial begin
    step(3);
    SRST = 1'b0;
    step(1);
    check("oe_n", TX_CLOCK_PIN_OE_N, 1'b1);
    check("flag", TX_BUFFER_EMPTY_FLAG, 1'b0);
    SERIAL_PORT_ENABLE = 1'b1;
    TX_ENABLE_BIT = 1'b1;
    step(10);
    check("flag", TX_BUFFER_EMPTY_FLAG, 1'b1);
    check("oe_n", TX_CLOCK_PIN_OE_N, 1'b0);
    check("line", TX_CLOCK_PIN_OUT, 1'b1);
    lo = 1'b0;
    refd = 1'b0;
    TX_HOLDING_BUFFER_WRITE = 1'b1;
    for (int i = 0; i < 12; i++) begin
      TX_HOLDING_BUFFER = 9'h030 + 9'(i);
      if (TX_BUFFER_EMPTY_FLAG === 1'b0) lo = 1'b1;
      step(1);
      // Ready registered at the write edge tells whether that edge took the word
      if (TX_HOLDING_READY === 1'b1) exp.push_back(TX_HOLDING_BUFFER);
      else refd = 1'b1;
    end
    TX_HOLDING_BUFFER_WRITE = 1'b0;
    // Flag holds still during writes, settles two instruction cycles later
    for (int i = 0; i < 12; i++) begin
      if (TX_BUFFER_EMPTY_FLAG === 1'b0) lo = 1'b1;
      step(1);
    end
    check("refused", refd, 1'b1);
    check("flag_low", lo, 1'b1);
    drain();
    check("flag", TX_BUFFER_EMPTY_FLAG, 1'b1);
    // Interrupt enabled only briefly, with nothing left to send
    TX_INTERRUPT_ENABLE = 1'b1;
    step(3);
    check("irq", TX_IRQ, 1'b1);
    TX_INTERRUPT_ENABLE = 1'b0;
    step(3);
    check("irq", TX_IRQ, 1'b0);
    $display("done: fill and flags");
    NINE_BIT_MODE = 1'b1;
    TX_POLARITY_BIT = 1'b1;
    step(4);
    check("line", TX_CLOCK_PIN_OUT, 1'b0);
    put(9'h1A5);
    drain();
    NINE_BIT_MODE = 1'b0;
    TX_POLARITY_BIT = 1'b0;
    BRG_16BIT = 1'b1;
    bit_clks = 264;
    step(8);
    put(9'h03C);
    drain();
    BRG_16BIT = 1'b0;
    bit_clks = 8;
    $display("done: format and baud");
    i_peer.send(9'h05A, 8, 1'b1);
    wait_rx();
    check("rx_data", {1'b0, RX_DATA_BUFFER[7:0]}, 9'h05A);
    check("framing_error_flag", FRAMING_ERROR_FLAG, 1'b0);
    rd();
    check("rx_ready", RX_READY_FLAG, 1'b0);
    i_peer.send(9'h000, 8, 1'b0);
    wait_rx();
    check("framing_error_flag", FRAMING_ERROR_FLAG, 1'b1);
    check("rx_data", {1'b0, RX_DATA_BUFFER[7:0]}, 9'h000);
    step(1);
    check("break", BREAK_DETECTED, 1'b1);
    rd();
    WAKE_ON_BREAK = 1'b1;
    i_peer.send(9'h000, 8, 1'b0);
    wait_rx();
    rd();
    WAKE_ON_BREAK = 1'b0;
    i_peer.send(9'h0C3, 8, 1'b1);
    wait_rx();
    check("rx_data", {1'b0, RX_DATA_BUFFER[7:0]}, 9'h0C3);
    rd();
    $display("done: receive and wake");
    TX_ENABLE_BIT = 1'b0;
    step(10);
    check("flag", TX_BUFFER_EMPTY_FLAG, 1'b0);
    put(9'h011);
    TX_ENABLE_BIT = 1'b1;
    SYNC_MODE = 1'b1;
    step(2);
    put(9'h022);
    step(200);
    exp.delete();
    check("frames", 9'(i_peer.got.size()), 9'h000);
    $display("done: disabled writes");
    finish_test();
  end
endmodule
`default_nettype wire

// ### verilog/serial_params.svh
// Constants for the asynchronous serial transmitter and break receiver
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define FIFO_DEPTH_DEF 8
`define DATA_W_DEF 9
`define BRG_W 16
`define BRG_LOW_W 8
`define FLAG_DELAY 2'h2
`define CYC_PER_INSTR 3'h4
`define BREAK_BYTE 8'h00
`define RX_SYNC_W 3
`endif

// ### verilog/serial_pkg.sv
// Types shared by the serial port design
package serial_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b011,
    RX_WAKE_LOW = 3'b100,
    RX_WAKE_HIGH = 3'b101
  } rx_state_t;
endpackage

// ### verilog/serial_port.sv
// Asynchronous serial transmitter with FIFO, and receiver with break detection
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"

module serial_fifo #(
  parameter int WIDTH = `DATA_W_DEF,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("serial_fifo: DEPTH must be a power of two >= 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module serial_port
  import serial_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic TX_ENABLE_BIT,
  input wire logic RX_ENABLE,
  input wire logic SYNC_MODE,
  input wire logic SERIAL_PORT_ENABLE,
  input wire logic TX_POLARITY_BIT,
  input wire logic NINE_BIT_MODE,
  input wire logic BRG_16BIT,
  input wire logic [`BRG_W-1:0] BRG_DIVISOR,
  input wire logic TX_INTERRUPT_ENABLE,
  input wire logic WAKE_ON_BREAK,
  input wire logic TX_HOLDING_BUFFER_WRITE,
  input wire logic [`DATA_W_DEF-1:0] TX_HOLDING_BUFFER,
  input wire logic RX_DATA_READ,
  input wire logic RX_DATA_PIN,
  output logic TX_CLOCK_PIN_OUT,
  output logic TX_CLOCK_PIN_OE_N,
  output logic TX_HOLDING_READY,
  output logic TX_BUFFER_EMPTY_FLAG,
  output logic TX_IRQ,
  output logic TX_BUSY,
  output logic RX_READY_FLAG,
  output logic FRAMING_ERROR_FLAG,
  output logic [`DATA_W_DEF-1:0] RX_DATA_BUFFER,
  output logic BREAK_DETECTED,
  output logic WAKE_ACTIVE
);
  localparam int DW = `DATA_W_DEF;
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("serial_port: FIFO_DEPTH must be at least 2");
    end
  end

  logic tx_active;
  assign tx_active = TX_ENABLE_BIT && !SYNC_MODE && SERIAL_PORT_ENABLE;

  // Baud tick for the transmitter only; the receiver reuses just the reload value
  logic [`BRG_W-1:0] brg_cnt;
  logic [`BRG_W-1:0] brg_reload;
  logic baud_tick;
  assign brg_reload = BRG_16BIT ? BRG_DIVISOR :
    {{(`BRG_W-`BRG_LOW_W){1'b0}}, BRG_DIVISOR[`BRG_LOW_W-1:0]};
  assign baud_tick = (brg_cnt == '0);
  always_ff @(posedge CLK_SYS) begin
    if (SRST || !SERIAL_PORT_ENABLE) begin
      brg_cnt <= '0;
    end else if (baud_tick) begin
      brg_cnt <= brg_reload;
    end else begin
      brg_cnt <= brg_cnt - 1'b1;
    end
  end

  // Holding buffer: an 8-word queue in front of the shifter
  logic q_valid;
  logic q_ready;
  logic q_in_ready;
  logic [DW-1:0] q_data;
  serial_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_hold (
    .clk(CLK_SYS),
    .srst(SRST),
    .flush(!tx_active),
    .in_valid(TX_HOLDING_BUFFER_WRITE && tx_active),
    .in_ready(q_in_ready),
    .in_data(TX_HOLDING_BUFFER),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  tx_state_t tx_state;
  logic [DW-1:0] transmit_shift_reg;
  logic [3:0] tx_bits;
  logic tx_level;
  // Shifter accepts when idle or as its stop bit ends
  assign q_ready = tx_active && (tx_state == TX_IDLE ||
    (tx_state == TX_STOP && baud_tick));

  always_ff @(posedge CLK_SYS) begin
    if (SRST || !tx_active) begin
      tx_state <= TX_IDLE;
      transmit_shift_reg <= '0;
      tx_bits <= '0;
      tx_level <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_level <= 1'b1;
          if (q_valid) begin
            transmit_shift_reg <= q_data;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (baud_tick) begin
            tx_level <= 1'b0;
            tx_bits <= NINE_BIT_MODE ? 4'h9 : 4'h8;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (baud_tick) begin
            if (tx_bits == 4'h0) begin
              tx_level <= 1'b1;
              tx_state <= TX_STOP;
            end else begin
              tx_level <= transmit_shift_reg[0];
              transmit_shift_reg <= transmit_shift_reg >> 1;
              tx_bits <= tx_bits - 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (baud_tick) begin
            if (q_valid) begin
              transmit_shift_reg <= q_data;
              tx_level <= 1'b0;
              tx_bits <= NINE_BIT_MODE ? 4'h9 : 4'h8;
              tx_state <= TX_DATA;
            end else begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      TX_CLOCK_PIN_OUT <= 1'b1;
      TX_CLOCK_PIN_OE_N <= 1'b1;
      TX_HOLDING_READY <= 1'b0;
      TX_BUSY <= 1'b0;
    end else begin
      TX_CLOCK_PIN_OE_N <= !SERIAL_PORT_ENABLE;
      // Sync mode reuses the polarity bit for the clock, so no inversion there
      TX_CLOCK_PIN_OUT <= (tx_active ? tx_level : 1'b1) ^
        (TX_POLARITY_BIT && !SYNC_MODE);
      TX_HOLDING_READY <= q_in_ready && tx_active;
      TX_BUSY <= tx_state != TX_IDLE;
    end
  end

  // Empty flag lags a write by two instruction cycles
  logic [2:0] cyc_cnt;
  logic [1:0] flag_delay;
  logic raw_empty;
  assign raw_empty = tx_active && !(q_valid && tx_state != TX_IDLE);
  always_ff @(posedge CLK_SYS) begin
    if (SRST || !tx_active) begin
      cyc_cnt <= '0;
      flag_delay <= '0;
    end else begin
      cyc_cnt <= (cyc_cnt == `CYC_PER_INSTR - 3'h1) ? 3'h0 : cyc_cnt + 3'h1;
      if (TX_HOLDING_BUFFER_WRITE) begin
        flag_delay <= `FLAG_DELAY;
      end else if (flag_delay != 2'h0 && cyc_cnt == `CYC_PER_INSTR - 3'h1) begin
        flag_delay <= flag_delay - 2'h1;
      end
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SRST || !tx_active) begin
      TX_BUFFER_EMPTY_FLAG <= 1'b0;
      TX_IRQ <= 1'b0;
    end else begin
      if (flag_delay == 2'h0 && !TX_HOLDING_BUFFER_WRITE) begin
        TX_BUFFER_EMPTY_FLAG <= raw_empty;
      end
      TX_IRQ <= TX_BUFFER_EMPTY_FLAG && TX_INTERRUPT_ENABLE;
    end
  end

  // Receiver: three-stage input synchroniser
  logic [`RX_SYNC_W-1:0] rx_sync;
  logic rx_in;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rx_sync <= '1;
      rx_in <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[`RX_SYNC_W-2:0], RX_DATA_PIN};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_in <= rx_sync[2];
      end
    end
  end

  // Half-bit timing from the shared divider
  rx_state_t rx_state;
  logic [`BRG_W:0] rx_cnt;
  logic [3:0] rx_bits;
  logic [DW-1:0] rx_shift;
  logic rx_sample;
  assign rx_sample = (rx_cnt == '0);
  always_ff @(posedge CLK_SYS) begin
    if (SRST || !SERIAL_PORT_ENABLE || !RX_ENABLE) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bits <= '0;
      rx_shift <= '0;
      RX_READY_FLAG <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
      RX_DATA_BUFFER <= '0;
      BREAK_DETECTED <= 1'b0;
      WAKE_ACTIVE <= 1'b0;
    end else begin
      BREAK_DETECTED <= RX_READY_FLAG && FRAMING_ERROR_FLAG &&
        RX_DATA_BUFFER[7:0] == `BREAK_BYTE;
      // New data wins over a same-cycle read
      if (RX_DATA_READ) begin
        RX_READY_FLAG <= 1'b0;
      end
      rx_cnt <= rx_sample ? rx_cnt : rx_cnt - 1'b1;
      case (rx_state)
        RX_IDLE: begin
          if (WAKE_ON_BREAK) begin
            WAKE_ACTIVE <= 1'b1;
            if (!rx_in) begin
              rx_state <= RX_WAKE_LOW;
            end
          end else if (!rx_in) begin
            rx_cnt <= {2'b00, brg_reload[`BRG_W-1:1]};
            rx_state <= RX_START;
          end
        end
        RX_WAKE_LOW: begin
          if (rx_in) begin
            RX_READY_FLAG <= 1'b1;
            WAKE_ACTIVE <= 1'b0;
            rx_state <= RX_WAKE_HIGH;
          end
        end
        RX_WAKE_HIGH: begin
          if (!rx_in) begin
            rx_cnt <= {2'b00, brg_reload[`BRG_W-1:1]};
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_cnt <= {1'b0, brg_reload};
            rx_bits <= NINE_BIT_MODE ? 4'h9 : 4'h8;
            rx_state <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_cnt <= {1'b0, brg_reload};
            rx_shift <= {rx_in, rx_shift[DW-1:1]};
            rx_bits <= rx_bits - 4'h1;
            if (rx_bits == 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            RX_DATA_BUFFER <= NINE_BIT_MODE ? rx_shift : {1'b0, rx_shift[DW-1:1]};
            RX_READY_FLAG <= 1'b1;
            FRAMING_ERROR_FLAG <= !rx_in;
            // Low stop means a break may still hold the line
            rx_state <= rx_in ? RX_IDLE : RX_WAKE_LOW;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire
